/* File: core/qdc_pkg.sv */
// Constants and types of the quad/octal DAC control-register block.
// Assumes a single 125 MHz system clock; serial port pins are asynchronous.
`default_nettype none

package qdc_pkg;

    // Channel storage is sized for the octal variant
    localparam int unsigned NUM_CH      = 8;
    localparam int unsigned WORD_W      = 16;
    localparam int unsigned MAIN_W      = 10;
    localparam int unsigned SUB_W       = 8;
    localparam int unsigned ADDR_W      = 3;
    localparam int unsigned CNT_W       = 5;

    // Bit positions inside the 16-bit serial word
    localparam int unsigned POS_MAIN_SUB     = 15;
    localparam int unsigned POS_KIND_LO      = 14;
    localparam int unsigned POS_KIND_HI      = 13;
    localparam int unsigned POS_ADDR_2       = 12;
    localparam int unsigned POS_ADDR_1       = 11;
    localparam int unsigned POS_ADDR_0       = 10;
    localparam int unsigned POS_CODING       = 6;
    localparam int unsigned POS_POWER_ON     = 5;
    localparam int unsigned POS_GLOBAL_SLEEP = 4;
    localparam int unsigned POS_GLOBAL_CLEAR = 3;
    localparam int unsigned POS_BIAS_HI      = 9;
    localparam int unsigned POS_BIAS_LO      = 8;
    localparam int unsigned POS_AWAKE        = 4;
    localparam int unsigned POS_CHAN_CLEAR   = 3;
    localparam int unsigned POS_MAIN_LSB     = 0;
    localparam int unsigned POS_SUB_LSB      = 2;

    // Last bit index of a frame
    localparam logic [CNT_W-1:0] LAST_BIT = 5'h0f;
    localparam logic [CNT_W-1:0] FULL_CNT = 5'h10;

    // Values after reset
    localparam logic RST_POWER_ON     = 1'b1;
    localparam logic RST_GLOBAL_SLEEP = 1'b1;
    localparam logic RST_GLOBAL_CLEAR = 1'b0;
    localparam logic RST_CODING       = 1'b0;
    localparam logic RST_AWAKE        = 1'b1;
    localparam logic RST_CHAN_CLEAR   = 1'b1;
    localparam logic [1:0] RST_BIAS   = 2'h0;
    localparam logic [MAIN_W-1:0] RST_MAIN = 10'h000;
    localparam logic [SUB_W-1:0]  RST_SUB  = 8'h00;

    // Stored code after a soft clear; level depends on coding
    localparam logic [MAIN_W-1:0] MAIN_CLEAR_CODE = 10'h000;

    // Coding select values
    localparam logic CODING_TWOS = 1'b0;
    localparam logic CODING_OFFSET_BINARY = 1'b1;

    // Register kind from bits 13 and 14
    typedef enum logic [1:0] {
        QDC_KIND_GLOBAL  = 2'b00,
        QDC_KIND_CHANNEL = 2'b01,
        QDC_KIND_DATA_A  = 2'b10,
        QDC_KIND_DATA_B  = 2'b11
    } qdc_kind_e;

    // Reference multiplexer choices
    typedef enum logic [1:0] {
        QDC_BIAS_HALF_SUPPLY = 2'b00,
        QDC_BIAS_BANDGAP     = 2'b01,
        QDC_BIAS_EXTERNAL    = 2'b10,
        QDC_BIAS_UNDEFINED   = 2'b11
    } qdc_bias_e;

    typedef struct packed {
        logic      awake;
        logic      soft_clear;
        qdc_bias_e bias;
    } qdc_chan_ctl_s;

    typedef struct packed {
        logic              active;
        qdc_bias_e         bias;
        logic [MAIN_W-1:0] main_level;
        logic [SUB_W-1:0]  sub_level;
    } qdc_chan_out_s;

    // Synchronised pin group
    typedef struct packed {
        logic sclk;
        logic fsync_n;
        logic sdata;
        logic update_n;
    } qdc_pins_s;

endpackage

`default_nettype wire

/* File: core/qdc_dac_ctrl.sv */
// Control registers of a serially loaded quad/octal 10-bit DAC.
// Assumes one 125 MHz clock; all serial pins come from the host, async.
// Function
// R1 - Power-on bit 0 powers down reference and DACs
// R2 - Power-down keeps every register content
// R3 - Coding bit: 0 twos complement, 1 offset binary
// R4 - Global sleep parks all DACs, reference stays
// R5 - Global soft clear clears main data, DAC
// R6 - Global clear level follows input coding
// R7 - Global clear leaves sub data untouched
// R8 - Quad variant ignores top address bit
// R9 - Octal variant decodes all three address bits
// R10 - Channel awake 0 parks only that DAC
// R11 - Channel clear clears main, keeps sub
// R12 - Channel clear acts on update strobe
// R13 - Channel clear: midscale or bottom by coding
// R14 - Bias bits pick half supply, bandgap, external
// R15 - Top bit selects sub or main data
// R16 - Sub data 8 bits, two LSBs ignored
// R17 - Sub code follows global coding
// R18 - Power-up: power on, global sleep set
// R19 - Channel defaults: awake, clear set, bias 00
// R20 - Host must leave sleep after power-up
// R21 - Bits 13/14 choose register kind
// R22 - Sample data on falling clock, frame low
// R23 - Update strobe low loads all DAC registers
// R24 - Commit word only after sixteen bits
`default_nettype none

module qdc_dac_ctrl #(
    parameter bit OCTAL = 1'b1                  // 1 octal, 0 quad
) (
    input  wire logic  clock,                   // 125 MHz system clock
    input  wire logic  reset_n,                 // Async reset, active low
    input  wire logic  clock_enable,            // Low freezes all state except the reset pipe rst_pipe_q
    input  wire logic  serial_clock,            // Host shift clock
    input  wire logic  frame_sync_n,            // Frame sync, active low
    input  wire logic  serial_data_input,       // Serial data, MSB first
    input  wire logic  output_update_strobe_n,  // Update strobe, active low
    output var  logic  reference_on,            // Reference powered
    output var  logic  power_down,              // Whole device powered down
    output var  logic  coding_select,           // 1 offset binary
    output var  qdc_pkg::qdc_chan_out_s [qdc_pkg::NUM_CH-1:0] chan_out // Per DAC
);

    logic [1:0]                   rst_pipe_q;
    logic                         rst_n;
    qdc_pkg::qdc_pins_s           pins;
    qdc_pkg::qdc_pins_s           sync1_q;
    qdc_pkg::qdc_pins_s           sync2_q;
    qdc_pkg::qdc_pins_s           sync3_q;
    qdc_pkg::qdc_pins_s           filt_q;
    qdc_pkg::qdc_pins_s           filt_prev_q;
    logic [3:0]                   agree;
    logic                         sclk_fall;
    logic                         update_fall;
    logic [qdc_pkg::WORD_W-1:0]   shift_q;
    logic [qdc_pkg::CNT_W-1:0]    bit_cnt_q;
    logic [qdc_pkg::WORD_W-1:0]   word_q;
    logic                         word_valid_q;
    qdc_pkg::qdc_kind_e           kind;
    logic [qdc_pkg::ADDR_W-1:0]   addr;
    logic                         wr_global;
    logic                         wr_channel;
    logic                         wr_main;
    logic                         wr_sub;
    logic                         power_on_q;
    logic                         global_sleep_q;
    logic                         global_clear_q;
    logic                         coding_q;

    // Reset release through two flops
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_pipe_q <= 2'h0;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end

    assign rst_n = rst_pipe_q[1];

    assign pins.sclk     = serial_clock;
    assign pins.fsync_n  = frame_sync_n;
    assign pins.sdata    = serial_data_input;
    assign pins.update_n = output_update_strobe_n;

    // Three-flop capture of host pins
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 4'hf;
            sync2_q <= 4'hf;
            sync3_q <= 4'hf;
        end else if (clock_enable) begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // A level counts only once stages two and three agree
    assign agree = ~(sync2_q ^ sync3_q);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            filt_q      <= 4'hf;
            filt_prev_q <= 4'hf;
        end else if (clock_enable) begin
            filt_q      <= (filt_q & ~agree) | (sync3_q & agree);
            filt_prev_q <= filt_q;
        end
    end

    // All pins share one delay, so data keeps its place against the edge
    assign sclk_fall   = filt_prev_q.sclk & ~filt_q.sclk;
    assign update_fall = filt_prev_q.update_n & ~filt_q.update_n;

    // Bit counter clears between frames and stops at sixteen
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_q <= 5'h00;
        end else if (clock_enable) begin
            if (filt_q.fsync_n) begin
                bit_cnt_q <= 5'h00;
            end else if (sclk_fall && bit_cnt_q != qdc_pkg::FULL_CNT) begin
                bit_cnt_q <= bit_cnt_q + 5'h01; // R22
            end
        end
    end

    // Serial shift register; extra bits past sixteen are dropped
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= 16'h0000;
        end else if (clock_enable && !filt_q.fsync_n && sclk_fall
                     && bit_cnt_q != qdc_pkg::FULL_CNT) begin
            shift_q <= {shift_q[qdc_pkg::WORD_W-2:0], filt_q.sdata}; // R22
        end
    end

    // Word is handed on only after its sixteenth bit
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            word_q       <= 16'h0000;
            word_valid_q <= 1'b0;
        end else if (clock_enable) begin
            word_valid_q <= 1'b0;
            if (!filt_q.fsync_n && sclk_fall
                    && bit_cnt_q == qdc_pkg::LAST_BIT) begin
                word_q       <= {shift_q[qdc_pkg::WORD_W-2:0], filt_q.sdata}; // R24
                word_valid_q <= 1'b1; // R24
            end
        end
    end

    // Kind bits: hi is bit 13, lo is bit 14
    assign kind = qdc_pkg::qdc_kind_e'({word_q[qdc_pkg::POS_KIND_HI],
                                        word_q[qdc_pkg::POS_KIND_LO]}); // R21

    // Quad variant folds the top address bit away
    assign addr = {OCTAL & word_q[qdc_pkg::POS_ADDR_2], // R8 R9
                   word_q[qdc_pkg::POS_ADDR_1],
                   word_q[qdc_pkg::POS_ADDR_0]};

    always_comb begin
        wr_global  = 1'b0;
        wr_channel = 1'b0;
        wr_main    = 1'b0;
        wr_sub     = 1'b0;
        case (kind)
            qdc_pkg::QDC_KIND_GLOBAL: begin
                wr_global = word_valid_q; // R21
            end
            qdc_pkg::QDC_KIND_CHANNEL: begin
                wr_channel = word_valid_q; // R21
            end
            qdc_pkg::QDC_KIND_DATA_A, qdc_pkg::QDC_KIND_DATA_B: begin
                wr_sub  = word_valid_q & word_q[qdc_pkg::POS_MAIN_SUB];  // R15
                wr_main = word_valid_q & ~word_q[qdc_pkg::POS_MAIN_SUB]; // R15
            end
            default: begin
                wr_global = 1'b0;
            end
        endcase
    end

    // Global control register: power and sleep bits
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            power_on_q     <= qdc_pkg::RST_POWER_ON;     // R18
            global_sleep_q <= qdc_pkg::RST_GLOBAL_SLEEP; // R18
        end else if (clock_enable && wr_global) begin
            power_on_q     <= word_q[qdc_pkg::POS_POWER_ON];     // R1
            global_sleep_q <= word_q[qdc_pkg::POS_GLOBAL_SLEEP]; // R4
        end
    end

    // Clear and coding bits; address bits of this word are ignored
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            global_clear_q <= qdc_pkg::RST_GLOBAL_CLEAR;
            coding_q       <= qdc_pkg::RST_CODING;
        end else if (clock_enable && wr_global) begin
            global_clear_q <= word_q[qdc_pkg::POS_GLOBAL_CLEAR]; // R5
            coding_q       <= word_q[qdc_pkg::POS_CODING];       // R3
        end
    end

    // Power-down only gates analog enables; no register is touched
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reference_on <= qdc_pkg::RST_POWER_ON;
        end else if (clock_enable) begin
            reference_on <= power_on_q; // R1 R4
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            power_down <= ~qdc_pkg::RST_POWER_ON;
        end else if (clock_enable) begin
            power_down <= ~power_on_q; // R1 R2
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            coding_select <= qdc_pkg::RST_CODING;
        end else if (clock_enable) begin
            coding_select <= coding_q; // R3
        end
    end

    // Per-channel registers
    for (genvar ch = 0; ch < qdc_pkg::NUM_CH; ch++) begin : g_chan
        qdc_pkg::qdc_chan_ctl_s       ctl_q;
        logic [qdc_pkg::MAIN_W-1:0]   main_data_q;
        logic [qdc_pkg::SUB_W-1:0]    sub_data_q;
        logic [qdc_pkg::MAIN_W-1:0]   dac_main_q;
        logic [qdc_pkg::SUB_W-1:0]    dac_sub_q;
        logic                         hit;
        logic                         active;
        logic [qdc_pkg::MAIN_W-1:0]   main_flip;
        logic [qdc_pkg::SUB_W-1:0]    sub_flip;
        logic                         ctl_wr;
        logic                         main_wr;
        logic                         sub_wr;
        logic                         strobe_clear;

        assign hit = (int'(addr) == ch); // R8 R9

        // Write and clear enables of this channel alone
        assign ctl_wr       = wr_channel & hit;
        assign main_wr      = wr_main & hit;
        assign sub_wr       = wr_sub & hit;
        assign strobe_clear = update_fall & ctl_q.soft_clear; // R12

        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                ctl_q.awake      <= qdc_pkg::RST_AWAKE;      // R19
                ctl_q.soft_clear <= qdc_pkg::RST_CHAN_CLEAR; // R19
                ctl_q.bias       <= qdc_pkg::qdc_bias_e'(qdc_pkg::RST_BIAS); // R19
            end else if (clock_enable && ctl_wr) begin
                ctl_q.awake      <= word_q[qdc_pkg::POS_AWAKE];      // R10
                ctl_q.soft_clear <= word_q[qdc_pkg::POS_CHAN_CLEAR]; // R11
                ctl_q.bias       <= qdc_pkg::qdc_bias_e'(
                    {word_q[qdc_pkg::POS_BIAS_HI],
                     word_q[qdc_pkg::POS_BIAS_LO]}); // R14
            end
        end

        // Global clear holds main data while set; channel clear on strobe
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                main_data_q <= qdc_pkg::RST_MAIN;
            end else if (clock_enable) begin
                if (global_clear_q) begin
                    main_data_q <= qdc_pkg::MAIN_CLEAR_CODE; // R5
                end else if (strobe_clear) begin
                    main_data_q <= qdc_pkg::MAIN_CLEAR_CODE; // R11 R12
                end else if (main_wr) begin
                    main_data_q <= word_q[qdc_pkg::POS_MAIN_LSB +:
                                          qdc_pkg::MAIN_W];
                end
            end
        end

        // Sub data sees no clear of either kind
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                sub_data_q <= qdc_pkg::RST_SUB;
            end else if (clock_enable && sub_wr) begin
                sub_data_q <= word_q[qdc_pkg::POS_SUB_LSB +:
                                     qdc_pkg::SUB_W]; // R7 R16
            end
        end

        // DAC registers load together on the strobe's falling edge
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                dac_main_q <= qdc_pkg::RST_MAIN;
            end else if (clock_enable) begin
                if (global_clear_q) begin
                    dac_main_q <= qdc_pkg::MAIN_CLEAR_CODE; // R5
                end else if (update_fall) begin
                    dac_main_q <= ctl_q.soft_clear
                                  ? qdc_pkg::MAIN_CLEAR_CODE // R12 R13
                                  : main_data_q;             // R23
                end
            end
        end

        // Sub DAC register; no clear of either kind reaches it
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                dac_sub_q <= qdc_pkg::RST_SUB;
            end else if (clock_enable && update_fall) begin
                dac_sub_q <= sub_data_q; // R23 R7
            end
        end

        // Converter sees straight binary; twos complement flips the MSB,
        // so a cleared code lands mid-scale or at the bottom by coding
        assign main_flip = {coding_q == qdc_pkg::CODING_TWOS, 9'h000}; // R6 R13
        assign sub_flip  = {coding_q == qdc_pkg::CODING_TWOS, 7'h00};  // R17

        // Sleep and channel standby stop the DAC but not the reference
        assign active = power_on_q & ~global_sleep_q & ctl_q.awake; // R1 R4 R10

        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                chan_out[ch] <= '0;
            end else if (clock_enable) begin
                chan_out[ch].active     <= active;
                chan_out[ch].bias       <= ctl_q.bias; // R14
                chan_out[ch].main_level <= dac_main_q ^ main_flip; // R6
                chan_out[ch].sub_level  <= dac_sub_q ^ sub_flip;   // R17
            end
        end
    end

endmodule

`default_nettype wire

/* File: dv/qdc_dac_ctrl_monitor.sv */
// Checker for the DAC control block, bound to its top module.
// Assumes one clock domain and the raw host pins as seen by the block.
`default_nettype none
module qdc_dac_ctrl_monitor #(
    parameter bit OCTAL = 1'b1                        // Variant
) (
    input wire logic clock,                           // System clock
    input wire logic reset_n,                         // Reset, active low
    input wire logic clock_enable,                    // Run enable
    input wire logic serial_clock,                    // Host shift clock
    input wire logic frame_sync_n,                    // Frame sync
    input wire logic serial_data_input,               // Serial data
    input wire logic output_update_strobe_n,          // Update strobe
    input wire logic reference_on,                    // Reference powered
    input wire logic power_down,                      // Device powered down
    input wire logic coding_select,                   // Coding
    input wire qdc_pkg::qdc_chan_out_s [qdc_pkg::NUM_CH-1:0] chan_out // DACs
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] act;
    logic       sclk_q;
    logic       upd_q;
    logic       cod_q;
    logic [7:0] fall_age_q;
    logic [7:0] upd_age_q;
    logic [7:0] cod_age_q;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            act[i] = chan_out[i].active;
        end
    end

    // Cycles since each cause; zero at reset so release changes pass
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sclk_q <= 1'b1;
            upd_q <= 1'b1;
            cod_q <= 1'b0;
            fall_age_q <= 8'h00;
            upd_age_q <= 8'h00;
            cod_age_q <= 8'h00;
        end else begin
            sclk_q <= serial_clock;
            upd_q <= output_update_strobe_n;
            cod_q <= coding_select;
            fall_age_q <= (sclk_q && !serial_clock) ? 8'h00 :
                          fall_age_q + 8'(fall_age_q != 8'hff);
            upd_age_q <= (upd_q && !output_update_strobe_n) ? 8'h00 :
                         upd_age_q + 8'(upd_age_q != 8'hff);
            cod_age_q <= (cod_q != coding_select) ? 8'h00 :
                         cod_age_q + 8'(cod_age_q != 8'hff);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    property p_ref_pair; reference_on != power_down; endproperty
    a_ref_pair: assert property (p_ref_pair)
        else $error("power flags disagree");
    property p_down_idle;
        power_down && $past(power_down) |-> act == 8'h00;
    endproperty
    a_down_idle: assert property (p_down_idle)
        else $error("dac active while powered down");
    property p_coding_cause;
        $changed(coding_select) |=> fall_age_q < 8'h11;
    endproperty
    a_coding_cause: assert property (p_coding_cause)
        else $error("coding changed without a word");
    property p_active_cause; $changed(act) |=> fall_age_q < 8'h11; endproperty
    a_active_cause: assert property (p_active_cause)
        else $error("standby changed without a word");
    property p_bias_cause;
        $changed(chan_out[1].bias) |=> fall_age_q < 8'h11;
    endproperty
    a_bias_cause: assert property (p_bias_cause)
        else $error("bias changed without a word");
    property p_sub_cause;
        $changed(chan_out[2].sub_level) |=>
            upd_age_q < 8'h0d || cod_age_q < 8'h04;
    endproperty
    a_sub_cause: assert property (p_sub_cause)
        else $error("sub level changed without strobe");
    property p_main_cause;
        $changed(chan_out[1].main_level) |=> upd_age_q < 8'h0d ||
            fall_age_q < 8'h11 || cod_age_q < 8'h04;
    endproperty
    a_main_cause: assert property (p_main_cause)
        else $error("main level changed without cause");
    property p_reset_out;
        $rose(reset_n) |-> ##5 (act == 8'h00 && reference_on &&
            !coding_select && chan_out[0].sub_level == 8'h80);
    endproperty
    a_reset_out: assert property (p_reset_out)
        else $error("wrong outputs after reset");

    c_coding: cover property ($changed(coding_select));
    c_active: cover property ($changed(act));
    c_strobe: cover property (upd_age_q == 8'h00);
endmodule
`default_nettype wire

/* File: dv/qdc_host_model.sv */
// Host model: drives the serial port and the update strobe.
// Assumes the bench calls send and strobe one at a time.
`default_nettype none
module qdc_host_model (
    input  wire logic clock,    // System clock
    output var  logic sclk,     // Shift clock, still between frames
    output var  logic fsync_n,  // Frame sync
    output var  logic sdata,    // Serial data
    output var  logic upd_n     // Update strobe
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sclk = 1'b1;
        fsync_n = 1'b1;
        sdata = 1'b0;
        upd_n = 1'b1;
    end

    // Top n bits of w, MSB first; fewer than 16 aborts the frame
    task automatic send(input logic [15:0] w, input int n);
        @(posedge clock);
        fsync_n <= 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            sdata <= w[i];
            #62.5 sclk <= 1'b0;
            #62.5 sclk <= 1'b1;
        end
        fsync_n <= 1'b1;
        // Released line must not look like held data
        sdata <= ~sdata;
        repeat (24) @(posedge clock);
    endtask

    task automatic strobe();
        @(posedge clock);
        upd_n <= 1'b0;
        repeat (5) @(posedge clock);
        upd_n <= 1'b1;
        repeat (12) @(posedge clock);
    endtask
endmodule
`default_nettype wire

/* File: dv/qdc_dac_ctrl_bench.sv */
// Self-checking bench for the DAC control block.
// Assumes the host model and monitor files are compiled first.
`default_nettype none
module qdc_dac_ctrl_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam bit OCTAL = 1'b1;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic clock_enable = 1'b1;
    logic sclk;
    logic fsync_n;
    logic sdata;
    logic upd_n;
    logic reference_on;
    logic power_down;
    logic coding_select;
    qdc_pkg::qdc_chan_out_s [qdc_pkg::NUM_CH-1:0] chan_out;
    logic [7:0] act;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;

    always #4 clock = ~clock;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            act[i] = chan_out[i].active;
        end
    end

    qdc_dac_ctrl #(.OCTAL(OCTAL)) uut (
        .clock(clock), .reset_n(reset_n), .clock_enable(clock_enable),
        .serial_clock(sclk), .frame_sync_n(fsync_n),
        .serial_data_input(sdata), .output_update_strobe_n(upd_n),
        .reference_on(reference_on), .power_down(power_down),
        .coding_select(coding_select), .chan_out(chan_out)
    );
    qdc_host_model host (
        .clock(clock), .sclk(sclk), .fsync_n(fsync_n), .sdata(sdata),
        .upd_n(upd_n)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] mn(input int c);
        return 16'(chan_out[c].main_level);
    endfunction
    function automatic logic [15:0] sb(input int c);
        return 16'(chan_out[c].sub_level);
    endfunction
    task automatic w(input logic [15:0] x);
        host.send(x, 16);
    endtask

    task automatic t_reset();
        check(16'({reference_on, power_down, coding_select}), 16'h0004);
        check(16'(act), 16'h0000);
        check(mn(0), 16'h0200);
        check(sb(0), 16'h0080);
        check(16'(chan_out[7].bias), 16'h0000);
        $display("test reset done");
    endtask

    task automatic t_power();
        w(16'h0020);
        check(16'(act), 16'h00ff);
        w(16'h0000);
        check(16'({power_down, act}), 16'h0100);
        w(16'h0030);
        check(16'({reference_on, act}), 16'h0100);
        w(16'h0020);
        check(16'({power_down, act}), 16'h00ff);
        $display("test power done");
    endtask

    task automatic t_bias();
        for (int c = 0; c < 8; c++) begin
            w(16'h4010 | 16'(c << 10) | 16'(c % 3 << 8));
        end
        for (int c = 0; c < 8; c++) begin
            check(16'(chan_out[c].bias), 16'(c % 3));
        end
        $display("test bias done");
    endtask

    task automatic t_data();
        w(16'h2955);
        w(16'he96b);
        check(mn(2), 16'h0200);
        host.strobe();
        check(mn(2), 16'h0355);
        check(sb(2), 16'h00da);
        w(16'h0060);
        check(mn(2), 16'h0155);
        check(sb(2), 16'h005a);
        check(mn(3), 16'h0000);
        host.send(16'h28aa, 12);
        host.strobe();
        check(mn(2), 16'h0155);
        $display("test data done");
    endtask

    task automatic t_clear();
        w(16'h4a18);
        check(mn(2), 16'h0155);
        host.strobe();
        check(mn(2), 16'h0000);
        check(sb(2), 16'h005a);
        w(16'h0020);
        check(mn(2), 16'h0200);
        w(16'h4a10);
        host.strobe();
        check(mn(2), 16'h0200);
        w(16'h5500);
        check(16'(act), 16'h00df);
        $display("test clear done");
    endtask

    task automatic t_global();
        w(16'h24ff);
        host.strobe();
        check(mn(1), 16'h02ff);
        w(16'h0028);
        check(mn(1), 16'h0200);
        check(sb(2), 16'h00da);
        w(16'h0068);
        check(mn(1), 16'h0000);
        w(16'h0060);
        host.strobe();
        check(mn(1), 16'h0000);
        $display("test global done");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // About 6700 cycles expected; three times that means a hang
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end

    initial begin
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        repeat (8) @(posedge clock);
        t_reset();
        t_power();
        t_bias();
        t_data();
        t_clear();
        t_global();
        conclude();
    end
endmodule

bind qdc_dac_ctrl qdc_dac_ctrl_monitor #(.OCTAL(OCTAL)) mon (
    .clock(clock), .reset_n(reset_n), .clock_enable(clock_enable),
    .serial_clock(serial_clock), .frame_sync_n(frame_sync_n),
    .serial_data_input(serial_data_input),
    .output_update_strobe_n(output_update_strobe_n),
    .reference_on(reference_on), .power_down(power_down),
    .coding_select(coding_select), .chan_out(chan_out)
);
`default_nettype wire
